//--- hw/pft_defines.vh
`ifndef PFT_DEFINES_VH
`define PFT_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PFT_MODE_OFS    8'h00
`define PFT_FBC_OFS     8'h04
`define PFT_DOFH_OFS    8'h08
`define PFT_UOFH_OFS    8'h0c
`define PFT_CSR_OFS     8'h10
`define PFT_STAT_OFS    8'h14
// ----------------------------------------
// reset values
// ----------------------------------------
`define PFT_MODE_RST    8'h00
`define PFT_FBC_RST     8'hff
`define PFT_DOFH_RST    8'h00
`define PFT_UOFH_RST    8'h00
`define PFT_CSR_RST     8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define PFT_PMD_HI      7
`define PFT_PMD_LO      6
`define PFT_PCR_BIT     5
`define PFT_PSM_BIT     4
`define PFT_CSR_OFD_HI  6
`define PFT_CSR_OFD_LO  5
`define PFT_CSR_DRE     4
`define PFT_CSR_OFU_HI  2
`define PFT_CSR_OFU_LO  1
`define PFT_CSR_URE     0
// ----------------------------------------
// mode codes and offset constants
// ----------------------------------------
`define PFT_MODE0       2'h0
`define PFT_MODE1       2'h1
`define PFT_MODE2       2'h2
`define PFT_DS_K0       12'h011
`define PFT_DS_K1       12'h021
`define PFT_DS_K2       12'h041
`define PFT_US_K0       12'h017
`define PFT_US_K1       12'h02f
`define PFT_US_K2       12'h05f
`define PFT_FRAME_HZ    8000
`endif

//--- hw/pft_frame_timing.v
// Behaviour
// - bit rate comes from highway clock and the single/double clock select, always single in mode 2
// - bit-count register holds bits-1, (bits-2)/2 or (bits-4)/4 per mode
// - recognized sync resets time slot and bit counters to frame start
// - counters wrap at frame length from bit-count value without sync
// - each sync period is checked against frame length into status flag
// - sync acts on a sampled low-to-high transition, never directly
// - sync edge select 0 samples on falling clock edge, 1 on rising
// - sampled sync edge marks internal first bit, mapped to external bit numbers
// - 8/9/10-bit offsets in modes 0/1/2 shift up and downstream frames by single bits
// - tx edge select 1 transmits on rising edge, 0 on following falling
// - rx edge select 0 samples on falling edge, 1 on following rising
// - downstream offset is bit number plus 17/33/65, mod length
// - upstream offset is bit number minus 23/47/95 plus length, mod length
// - mode field 00, 01, 10 selects 4, 2 or 1 logical ports
`include "pft_defines.vh"

module pft_frame_timing (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        highway_bit_clock,
  input  wire        frame_sync_in,
  output reg         bit_tick,
  output reg         tx_strobe,
  output reg         rx_strobe,
  output reg  [6:0]  time_slot,
  output reg  [2:0]  slot_bit,
  output reg  [9:0]  downstream_bit,
  output reg  [9:0]  upstream_bit,
  output reg  [2:0]  port_count,
  output reg         sync_status_flag
);

// ----------------------------------------
// helper functions
// ----------------------------------------
// frame length in bits from bit-count value
function [10:0] frame_len;
  input [1:0] mode;
  input [7:0] fbc;
  begin
    case (mode)
      `PFT_MODE1: frame_len = {2'h0, fbc, 1'b0} + 11'h002;
      `PFT_MODE2: frame_len = {1'b0, fbc, 2'h0} + 11'h004;
      default:    frame_len = {3'h0, fbc} + 11'h001;
    endcase
  end
endfunction

// shift value with the mode's unused low bits dropped
function [11:0] shift_val;
  input [1:0] mode;
  input [9:0] sh;
  begin
    case (mode)
      `PFT_MODE1: shift_val = {3'h0, sh[9:1]};
      `PFT_MODE2: shift_val = {2'h0, sh};
      default:    shift_val = {4'h0, sh[9:2]};
    endcase
  end
endfunction

// reduce a sum below three frame lengths to modulo length
function [9:0] wrap;
  input [11:0] sum;
  input [10:0] len;
  reg   [11:0] s;
  begin
    s = sum;
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    wrap = s[9:0];
  end
endfunction

// ----------------------------------------
// register file and bus slave
// ----------------------------------------
reg  [7:0]  mode_r;
reg  [7:0]  fbc_r;
reg  [7:0]  dofh_r;
reg  [7:0]  uofh_r;
reg  [7:0]  csr_r;
reg         wr_pend_r;
reg  [7:0]  wr_addr_r;
wire        acc_ok;
wire [7:0]  acc_addr;
reg  [7:0]  rd_nxt;

assign acc_ok   = hsel & hready & htrans[1];
assign acc_addr = haddr[7:0];

// read mux, unmapped addresses read zero
always @* begin
  rd_nxt = 8'h00;
  if (haddr[31:8] == 24'h000000) begin
    case (acc_addr)
      `PFT_MODE_OFS: rd_nxt = mode_r;
      `PFT_FBC_OFS:  rd_nxt = fbc_r;
      `PFT_DOFH_OFS: rd_nxt = dofh_r;
      `PFT_UOFH_OFS: rd_nxt = uofh_r;
      `PFT_CSR_OFS:  rd_nxt = csr_r & 8'h77;
      `PFT_STAT_OFS: rd_nxt = {7'h00, sync_status_flag};
      default:       rd_nxt = 8'h00;
    endcase
  end
end

// address phase capture, zero-wait answer
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    wr_pend_r <= 1'b0;
    wr_addr_r <= 8'h00;
    hrdata    <= 32'h00000000;
    hreadyout <= 1'b0;
    hresp     <= 1'b0;
  end else begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
    wr_pend_r <= acc_ok & hwrite & (haddr[31:8] == 24'h000000);
    wr_addr_r <= acc_addr;
    if (acc_ok & ~hwrite) begin
      hrdata <= {24'h000000, rd_nxt};
    end
  end
end

// data phase write, unmapped writes ignored
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    mode_r <= `PFT_MODE_RST;
    fbc_r  <= `PFT_FBC_RST;
    dofh_r <= `PFT_DOFH_RST;
    uofh_r <= `PFT_UOFH_RST;
    csr_r  <= `PFT_CSR_RST;
  end else if (wr_pend_r) begin
    case (wr_addr_r)
      `PFT_MODE_OFS: mode_r <= hwdata[7:0];
      `PFT_FBC_OFS:  fbc_r  <= hwdata[7:0];
      `PFT_DOFH_OFS: dofh_r <= hwdata[7:0];
      `PFT_UOFH_OFS: uofh_r <= hwdata[7:0];
      `PFT_CSR_OFS:  csr_r  <= hwdata[7:0] & 8'h77;
      default:       mode_r <= mode_r;
    endcase
  end
end

// ----------------------------------------
// decoded configuration
// ----------------------------------------
wire [1:0]  pmode;
wire        clk_dbl;
wire [10:0] flen;
wire [11:0] ds_sh;
wire [11:0] us_sh;
reg  [11:0] ds_k;
reg  [11:0] us_k;

assign pmode = {mode_r[`PFT_PMD_HI], mode_r[`PFT_PMD_LO]};
// double clock not used in mode 2
assign clk_dbl = mode_r[`PFT_PCR_BIT] & (pmode != `PFT_MODE2);
assign flen  = frame_len(pmode, fbc_r);
assign ds_sh = shift_val(pmode, {dofh_r, csr_r[`PFT_CSR_OFD_HI], csr_r[`PFT_CSR_OFD_LO]});
assign us_sh = shift_val(pmode, {uofh_r, csr_r[`PFT_CSR_OFU_HI], csr_r[`PFT_CSR_OFU_LO]});

// mode constants of the offset formulas
always @* begin
  case (pmode)
    `PFT_MODE1: begin
      ds_k = `PFT_DS_K1;
      us_k = `PFT_US_K1;
    end
    `PFT_MODE2: begin
      ds_k = `PFT_DS_K2;
      us_k = `PFT_US_K2;
    end
    default: begin
      ds_k = `PFT_DS_K0;
      us_k = `PFT_US_K0;
    end
  endcase
end

// ----------------------------------------
// link pin synchronisers and edge finding
// ----------------------------------------
reg  [1:0] pdc_s_r;
reg  [1:0] pfs_s_r;
reg        pdc_d_r;
wire       pdc_rise;
wire       pdc_fall;

// two flops per pin, third for edge detect
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    pdc_s_r <= 2'h0;
    pfs_s_r <= 2'h0;
    pdc_d_r <= 1'b0;
  end else begin
    pdc_s_r <= {pdc_s_r[0], highway_bit_clock};
    pfs_s_r <= {pfs_s_r[0], frame_sync_in};
    pdc_d_r <= pdc_s_r[1];
  end
end

assign pdc_rise = pdc_s_r[1] & ~pdc_d_r;
assign pdc_fall = ~pdc_s_r[1] & pdc_d_r;

// ----------------------------------------
// frame sync sampling
// ----------------------------------------
reg  fs_samp_r;
wire fs_edge;
wire samp_now;

// sampling edge chosen by select bit
assign samp_now = mode_r[`PFT_PSM_BIT] ? pdc_rise : pdc_fall;
assign fs_edge  = samp_now & pfs_s_r[1] & ~fs_samp_r;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    fs_samp_r <= 1'b0;
  end else if (samp_now) begin
    fs_samp_r <= pfs_s_r[1];
  end
end

// ----------------------------------------
// bit and slot counters
// ----------------------------------------
reg  [9:0] bit_cnt_r;
reg        phase_r;
reg        sync_r;
reg        wrapped_r;
wire       adv;
wire [9:0] last_bit;

assign last_bit = flen[9:0] - 10'h001;
// rate set by clock and clock rate select, single rate in mode 2
assign adv = pdc_rise & (~clk_dbl | phase_r);

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    bit_cnt_r <= 10'h000;
    phase_r   <= 1'b0;
    sync_r    <= 1'b0;
    wrapped_r <= 1'b0;
  end else if (fs_edge) begin
    // sync edge is internal bit zero
    bit_cnt_r <= 10'h000;
    phase_r   <= 1'b0;
    wrapped_r <= 1'b0;
    // rise sync hits last bit, fall sync lands just after wrap
    sync_r    <= mode_r[`PFT_PSM_BIT] ? (bit_cnt_r == last_bit)
                                      : (wrapped_r & (bit_cnt_r == 10'h000));
  end else begin
    if (pdc_rise) begin
      phase_r <= clk_dbl & ~phase_r;
    end
    if (adv) begin
      bit_cnt_r <= (bit_cnt_r >= last_bit) ? 10'h000 : bit_cnt_r + 10'h001;
      wrapped_r <= (bit_cnt_r >= last_bit);
    end
  end
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
wire tx_edge;
wire rx_edge;
wire first_clk;

// first clock of a bit period
assign first_clk = ~clk_dbl | ~phase_r;
// rise at bit start, else the next fall
assign tx_edge = csr_r[`PFT_CSR_URE] ? adv : (pdc_fall & first_clk);
assign rx_edge = csr_r[`PFT_CSR_DRE] ? pdc_rise : pdc_fall;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    bit_tick         <= 1'b0;
    tx_strobe        <= 1'b0;
    rx_strobe        <= 1'b0;
    time_slot        <= 7'h00;
    slot_bit         <= 3'h0;
    downstream_bit   <= 10'h000;
    upstream_bit     <= 10'h000;
    port_count       <= 3'h4;
    sync_status_flag <= 1'b0;
  end else begin
    bit_tick         <= adv;
    tx_strobe        <= tx_edge;
    rx_strobe        <= rx_edge & first_clk;
    time_slot        <= bit_cnt_r[9:3];
    slot_bit         <= bit_cnt_r[2:0];
    downstream_bit   <= wrap({2'h0, bit_cnt_r} + ds_sh + ds_k, flen);
    upstream_bit     <= wrap({2'h0, bit_cnt_r} + us_sh + {1'b0, flen} - us_k, flen);
    case (pmode)
      `PFT_MODE1: port_count <= 3'h2;
      `PFT_MODE2: port_count <= 3'h1;
      default:    port_count <= 3'h4;
    endcase
    sync_status_flag <= sync_r;
  end
end

endmodule // pft_frame_timing

//--- dv/pft_frame_timing_sva.sv
module pft_frame_timing_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       bit_tick,
  input wire logic       tx_strobe,
  input wire logic       rx_strobe,
  input wire logic [6:0] time_slot,
  input wire logic [2:0] slot_bit,
  input wire logic [2:0] port_count,
  input wire logic       sync_status_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [9:0] cnt = {time_slot, slot_bit}; // internal bit position
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_count_step: assert property (
    cnt != $past(cnt) && cnt != 10'h0 |-> cnt == $past(cnt) + 10'h1) else $error("count skip");
  a_tick_pulse: assert property (bit_tick |=> !bit_tick) else $error("tick long");
  a_tx_pulse: assert property (tx_strobe |=> !tx_strobe) else $error("tx long");
  a_rx_pulse: assert property (rx_strobe |=> !rx_strobe) else $error("rx long");
  a_ports_legal: assert property (
    port_count inside {3'h1, 3'h2, 3'h4}) else $error("bad port count");
  a_lock_start: assert property (
    $rose(sync_status_flag) |-> ##[0:2] cnt == 10'h0) else $error("lock off start");
  // slave never stalls once out of reset
  a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("stall");
  // response is always okay
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad resp");
endmodule // pft_frame_timing_sva

bind pft_frame_timing pft_frame_timing_sva i_pft_frame_timing_sva (
  .hclk, .hresetn, .hreadyout, .hresp, .bit_tick, .tx_strobe, .rx_strobe,
  .time_slot, .slot_bit, .port_count, .sync_status_flag);

//--- dv/pft_highway_src.sv
module pft_highway_src (
  input  wire logic sync_en,
  input  wire logic [31:0] clk_per_frame,
  output logic      highway_bit_clock,
  output logic      frame_sync_in
);
  timeunit 1ns;
  timeprecision 10ps;
  int n = 0;
  // free-running bit clock, sync moved mid-high phase
  initial begin
    highway_bit_clock = 1'b0;
    frame_sync_in = 1'b0;
    forever begin
      #62.5 highway_bit_clock = 1'b1;
      // sync stable at both edges, low between pulses
      #31.25 frame_sync_in = sync_en && n < 3;
      n = n + 1 >= clk_per_frame ? 0 : n + 1;
      #31.25 highway_bit_clock = 1'b0;
    end
  end
endmodule // pft_highway_src

//--- dv/pft_frame_timing_test.sv
module pft_frame_timing_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk, hresetn, hsel, hwrite, probe, dp_rd, sync_en, hreadyout, hresp;
  logic        bclk, fsync, bit_tick, tx_strobe, rx_strobe, locked;
  logic [31:0] haddr, hwdata, hrdata, probe_val;
  logic [1:0]  htrans;
  logic [2:0]  hsize, slot_bit, port_count;
  logic [6:0]  time_slot;
  logic [9:0]  ds_bit, us_bit, cnt_prev, wrap_from;
  logic [31:0] eq[$];
  string       probe_nm;
  int          n_errors, checks_done, ticks, frame_ticks, wraps, cpf;
  int          txs, rxs, frame_tx, frame_rx;
  wire  [9:0]  cnt = {time_slot, slot_bit};
  logic [1:0]  r_m[4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  logic [1:0]  r_cs[4] = '{2'h0, 2'h1, 2'h3, 2'h0}; // clock rate, sync edge
  int          r_b[4] = '{64, 128, 32, 128}; // multiples of 32, 64, 128 per mode
  logic [7:0]  r_do[4] = '{8'h30, 8'h3a, 8'h00, 8'h10};
  logic [7:0]  r_uo[4] = '{8'h19, 8'h17, 8'h00, 8'h10};
  logic [7:0]  r_sh[4] = '{8'h01, 8'h11, 8'h11, 8'h60};

  pft_frame_timing i_pft_frame_timing (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .highway_bit_clock(bclk), .frame_sync_in(fsync), .bit_tick, .tx_strobe, .rx_strobe,
    .time_slot, .slot_bit, .downstream_bit(ds_bit), .upstream_bit(us_bit), .port_count,
    .sync_status_flag(locked));
  pft_highway_src i_pft_highway_src (.sync_en, .clk_per_frame(cpf),
    .highway_bit_clock(bclk), .frame_sync_in(fsync));

  // system clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    finish_test();
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) hang();
  endtask
  // one single word transfer; reads note their expected data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) eq.push_back(e);
    rdy();
  endtask
  // hand a settled pin value to the monitor
  task automatic peek(input string nm, input logic [31:0] v, e);
    @(negedge hclk);
    eq.push_back(e);
    probe_nm = nm;
    probe_val = v;
    probe = 1'b1;
    @(negedge hclk);
    probe = 1'b0;
  endtask
  task automatic wait_wr(input int n);
    int k, w0;
    w0 = wraps;
    k = 0;
    while (wraps < w0 + n && k < 5000 * n) begin
      @(negedge hclk);
      k++;
    end
    if (wraps < w0 + n) hang();
  endtask

  // compare each noted result as it appears
  always @(posedge hclk) begin
    if (dp_rd === 1'b1 && hreadyout === 1'b1) check("hrdata", hrdata, eq.pop_front());
    if (probe === 1'b1) check(probe_nm, probe_val, eq.pop_front());
    dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  // frame length and bits per frame, measured at each wrap
  always @(posedge hclk) begin
    cnt_prev <= cnt;
    ticks <= ticks + (bit_tick === 1'b1);
    txs <= txs + (tx_strobe === 1'b1 && bit_tick === 1'b1);
    rxs <= rxs + (rx_strobe === 1'b1);
    if (cnt == 10'h0 && cnt_prev != 10'h0) begin
      wraps <= wraps + 1;
      wrap_from <= cnt_prev;
      frame_ticks <= ticks;
      ticks <= int'(bit_tick === 1'b1);
      frame_tx <= txs;
      txs <= int'(tx_strobe === 1'b1 && bit_tick === 1'b1);
      frame_rx <= rxs;
      rxs <= int'(rx_strobe === 1'b1);
    end
  end

  // main sequence
  initial begin
    logic [7:0] v;
    int m, b, ofd, ofu;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    probe = 1'b0;
    sync_en = 1'b0;
    cpf = 64;
    void'($urandom(32'hccb297c1));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped word reads zero
    for (int i = 0; i < 7; i++) bus(1'b0, 8'(4 * i), 0, i == 1 ? 32'hff : 0);
    // random write and read back
    for (int i = 1; i < 5; i++) begin
      v = 8'($urandom);
      bus(1'b1, 8'(4 * i), {24'h0, v}, 0);
      bus(1'b0, 8'(4 * i), 0, {24'h0, i == 4 ? v & 8'h77 : v});
    end
    // status is read only, unmapped writes dropped
    bus(1'b1, 8'h14, 32'h1, 0);
    bus(1'b1, 8'h18, 32'hff, 0);
    bus(1'b0, 8'h14, 0, 0);
    bus(1'b0, 8'h18, 0, 0);
    for (int r = 0; r < 4; r++) begin
      m = r_m[r];
      b = r_b[r];
      ofd = m == 0 ? r_do[r] : m == 1 ? {r_do[r], r_sh[r][6]} : {r_do[r], r_sh[r][6:5]};
      ofu = m == 0 ? r_uo[r] : m == 1 ? {r_uo[r], r_sh[r][2]} : {r_uo[r], r_sh[r][2:1]};
      // mode, edges and bit count per mode
      bus(1'b1, 8'h00, {24'h0, r_m[r], r_cs[r], 4'h0}, 0);
      bus(1'b1, 8'h04, m == 0 ? b - 1 : m == 1 ? (b - 2) / 2 : (b - 4) / 4, 0);
      bus(1'b1, 8'h08, {24'h0, r_do[r]}, 0);
      bus(1'b1, 8'h0c, {24'h0, r_uo[r]}, 0);
      bus(1'b1, 8'h10, {24'h0, r_sh[r]}, 0);
      // clocks per frame from bits and clock rate
      cpf = r_cs[r][1] ? 2 * b : b;
      sync_en = 1'b1;
      wait_wr(4);
      bus(1'b0, 8'h14, 0, 1);
      wait_wr(1);
      peek("ds_bit", ds_bit, (ofd + (m == 0 ? 17 : m == 1 ? 33 : 65)) % b);
      peek("us_bit", us_bit, (ofu - (m == 0 ? 23 : m == 1 ? 47 : 95) + b) % b);
      peek("ports", port_count, m == 0 ? 4 : m == 1 ? 2 : 1);
      // free run without sync
      sync_en = 1'b0;
      wait_wr(2);
      peek("wrap_from", wrap_from, b - 1);
      peek("bits", frame_ticks, b);
      peek("tx_on_tick", frame_tx, r_sh[r][0] ? b : 0);
      peek("rx_per_frame", frame_rx, b);
      // sync eight bits late
      cpf = cpf + (r_cs[r][1] ? 16 : 8);
      sync_en = 1'b1;
      wait_wr(3);
      bus(1'b0, 8'h14, 0, 0);
    end
    repeat (2) @(posedge hclk);
    finish_test();
  end
endmodule // pft_frame_timing_test
